// File: design/cls_host.sv
// Purpose: Host end: builds frames, makes the link clock, reads returns.
// Assumes: Words arrive through the buffer; a start pulse opens a frame.
// Notes: The link clock pauses while the buffer runs dry mid frame.
`timescale 1ns/1ns
module cls_host #(
   parameter int DIV = cls_pkg::LINK_DIV,
   parameter int TAIL_W = cls_pkg::TAIL_W_DEF
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   cls_link_if.host_mp lnk,
   input wire logic i_wr_valid,
   input wire logic [cls_pkg::WORD_W-1:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_start,
   input wire logic [1:0] i_cmd,
   input wire logic [9:0] i_nwords,
   input wire logic [TAIL_W-1:0] i_tail,
   output logic o_busy,
   output logic o_rx_done,
   output logic [cls_pkg::CNT_W-1:0] o_fault_cnt,
   output logic o_tail_ok
);
   typedef enum logic [1:0] {
      TX_IDLE = 2'h0, TX_HDR = 2'h1, TX_DATA = 2'h3, TX_TAIL = 2'h2
   } cls_tx_type;
   typedef enum logic [1:0] {
      RX_OFF = 2'h0, RX_HDR = 2'h1, RX_TAIL = 2'h3
   } cls_rx_type;

   localparam int HB = cls_pkg::HDR_BITS;
   localparam int WW = cls_pkg::WORD_W;

   cls_tx_type tst_q, tst_d;          // Transmit state
   cls_rx_type rst_q, rst_d;          // Return state
   logic [4:0] div_q, div_d;          // Clock divider phase
   logic lclk_q, lclk_d;              // Link clock out
   logic sdo_q, sdo_d;                // Serial data out
   logic ld_q, ld_d;                  // Load strobe out
   logic [HB-1:0] tx_q, tx_d;         // Outgoing shift register
   logic [5:0] bc_q, bc_d;            // Bits left in segment
   logic [9:0] wc_q, wc_d;            // Words left after current
   logic pend_q, pend_d;              // Start taken, frame not begun
   logic [1:0] cmd_q, cmd_d;          // Latched command
   logic [9:0] nw_q, nw_d;            // Latched word count
   logic [TAIL_W-1:0] tail_q, tail_d; // Latched tail pattern
   logic busy_q, busy_d;
   logic [1:0] rs1_q, rs2_q;          // Return pair synchroniser
   logic [HB-1:0] rsr_q, rsr_d;       // Returned bit history
   logic [5:0] rbc_q, rbc_d;          // Tail bits left to check
   logic done_q, done_d;
   logic [9:0] fcnt_q, fcnt_d;
   logic tok_q, tok_d;
   logic fall_t, rise_t, need, stall;
   logic f_valid, f_pop;
   logic [WW-1:0] f_data;

   ////////////////////////////////////////////////////////////////////////////
   // Word buffer; its ready is the user's back-pressure
   cls_fifo #(.W(WW), .D(cls_pkg::FIFO_DEPTH)) u_fifo (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_in_valid(i_wr_valid),
      .i_in_data(i_wr_data),
      .o_in_ready(o_wr_ready),
      .o_out_valid(f_valid),
      .o_out_data(f_data),
      .i_out_ready(f_pop)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state: divider, transmit and return logic
   always_comb begin
      tst_d = tst_q;
      rst_d = rst_q;
      sdo_d = sdo_q;
      ld_d = ld_q;
      tx_d = tx_q;
      bc_d = bc_q;
      wc_d = wc_q;
      pend_d = pend_q;
      cmd_d = cmd_q;
      nw_d = nw_q;
      tail_d = tail_q;
      rsr_d = rsr_q;
      rbc_d = rbc_q;
      done_d = 1'b0;
      fcnt_d = fcnt_q;
      tok_d = tok_q;
      f_pop = 1'b0;
      // A new word is due when a header or word just ran out
      need = (tst_q == TX_HDR && bc_q == 6'h01 && nw_q != 10'h000) ||
             (tst_q == TX_DATA && bc_q == 6'h01 && wc_q != 10'h000);
      stall = (div_q == 5'(DIV / 2 - 1)) && need && !f_valid;
      fall_t = (div_q == 5'(DIV / 2 - 1)) && !stall;
      rise_t = (div_q == 5'(DIV - 1));
      div_d = stall ? div_q : (rise_t ? 5'h00 : 5'(div_q + 1'b1));
      lclk_d = (div_d < 5'(DIV / 2));
      // Take a start only while idle
      if (i_start && !busy_q) begin
         pend_d = 1'b1;
         cmd_d = i_cmd;
         nw_d = i_nwords;
         tail_d = i_tail;
         rst_d = RX_HDR;
      end
      // Data and load change on the falling link edge
      if (fall_t) begin
         unique case (tst_q)
            TX_IDLE: begin
               sdo_d = 1'b0;
               ld_d = 1'b0;
               if (pend_q) begin
                  pend_d = 1'b0;
                  // Counter field always leaves the host at zero
                  tx_d = {cls_pkg::SYNC_PAT, cmd_q, cmd_q, cmd_q,
                          cls_pkg::CNT_HOST_INIT};
                  bc_d = 6'(HB);
                  tst_d = TX_HDR;
               end
            end
            default: begin
               sdo_d = tx_q[HB-1];
               tx_d = {tx_q[HB-2:0], 1'b0};
               bc_d = 6'(bc_q - 1'b1);
               // Load rises with the first command bit
               if (tst_q == TX_HDR && bc_q == 6'(HB - cls_pkg::CMD_FIRST_BIT)) begin
                  ld_d = 1'b1;
               end
               if (bc_q == 6'h01) begin
                  if (need) begin
                     // Words go MSB first, as the user ordered them
                     f_pop = 1'b1;
                     tx_d = {f_data, 8'h00};
                     bc_d = 6'(WW);
                     wc_d = (tst_q == TX_HDR) ? 10'(nw_q - 1'b1) : 10'(wc_q - 1'b1);
                     tst_d = TX_DATA;
                  end else if (tst_q == TX_TAIL) begin
                     tst_d = TX_IDLE;
                  end else begin
                     tx_d = HB'(tail_q) << (HB - TAIL_W);
                     bc_d = 6'(TAIL_W);
                     tst_d = TX_TAIL;
                  end
               end
            end
         endcase
      end
      // Returned pair is sampled with the rising link edge
      if (rise_t) begin
         rsr_d = {rsr_q[HB-2:0], rs2_q[0]};
         unique case (rst_q)
            RX_OFF: begin
            end
            RX_HDR: begin
               if (rsr_d[HB-1:HB-8] == cls_pkg::SYNC_PAT && rs2_q[1]) begin
                  fcnt_d = rsr_d[9:0];
                  rbc_d = 6'(TAIL_W);
                  rst_d = RX_TAIL;
               end
            end
            RX_TAIL: begin
               rbc_d = 6'(rbc_q - 1'b1);
               if (rbc_q == 6'h01) begin
                  tok_d = (rsr_d[TAIL_W-1:0] == tail_q);
                  done_d = 1'b1;
                  rst_d = RX_OFF;
               end
            end
            default: begin
               rst_d = RX_OFF;
            end
         endcase
      end
      busy_d = pend_d || (tst_d != TX_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tst_q <= TX_IDLE;
         rst_q <= RX_OFF;
         div_q <= '0;
         lclk_q <= 1'b0;
         sdo_q <= 1'b0;
         ld_q <= 1'b0;
         tx_q <= '0;
         bc_q <= '0;
         wc_q <= '0;
         pend_q <= 1'b0;
         cmd_q <= '0;
         nw_q <= '0;
         tail_q <= '0;
         busy_q <= 1'b0;
         rs1_q <= '0;
         rs2_q <= '0;
         rsr_q <= '0;
         rbc_q <= '0;
         done_q <= 1'b0;
         fcnt_q <= '0;
         tok_q <= 1'b0;
      end else begin
         tst_q <= tst_d;
         rst_q <= rst_d;
         div_q <= div_d;
         lclk_q <= lclk_d;
         sdo_q <= sdo_d;
         ld_q <= ld_d;
         tx_q <= tx_d;
         bc_q <= bc_d;
         wc_q <= wc_d;
         pend_q <= pend_d;
         cmd_q <= cmd_d;
         nw_q <= nw_d;
         tail_q <= tail_d;
         busy_q <= busy_d;
         // Return pair comes from the link domain
         rs1_q <= {lnk.ret_load, lnk.ret_data};
         rs2_q <= rs1_q;
         rsr_q <= rsr_d;
         rbc_q <= rbc_d;
         done_q <= done_d;
         fcnt_q <= fcnt_d;
         tok_q <= tok_d;
      end
   end

   assign lnk.link_clk = lclk_q;
   assign lnk.fwd_data = sdo_q;
   assign lnk.fwd_load = ld_q;
   assign o_busy = busy_q;
   assign o_rx_done = done_q;
   assign o_fault_cnt = fcnt_q;
   assign o_tail_ok = tok_q;
endmodule // cls_host

// File: pkg/cls_pkg.sv
// Purpose: Shared constants and types of the cascaded LED serial link.
// Assumes: Both link ends and the bench compile this package first.
// Notes: Header is sync byte, command pair three times, fault counter.
package cls_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Header layout
   localparam logic [7:0] SYNC_PAT = 8'hE8;      // Fixed sync byte
   localparam int HDR_BITS = 24;                 // Whole header length
   localparam int CNT_W = 10;                    // Fault counter width
   localparam int CMD_FIRST_BIT = 8;             // Stream index of first command bit
   localparam int CMD_SECOND_BIT = 9;            // Command pair is complete here
   localparam int CNT_LAST_BIT = 23;             // Stream index of last counter bit
   localparam int LOAD_LATE_BIT = 10;            // Load must be high by this bit
   localparam logic [9:0] CNT_HOST_INIT = 10'h000; // Host always sends zero

   ////////////////////////////////////////////////////////////////////////////
   // Data set sizing
   localparam int OUTPUTS = 16;                  // Outputs per device
   localparam int SET_SHORT = 16;                // Bits per device, byte commands
   localparam int PWM_W_DEF = 12;                // PWM word width, 12 or 14
   localparam int WORD_W = 16;                   // Host word width
   localparam int FIFO_DEPTH = 16;               // Host word buffer depth
   localparam int TAIL_W_DEF = 8;                // Tail length sent by host
   localparam int POS_W = 10;                    // Frame position counter width

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS = 8;                    // System clock period
   localparam int LINK_MIN_NS = 30;              // Fastest legal link period
   // Divider is rounded up so the link never exceeds its top rate
   localparam int LINK_DIV_RAW = (LINK_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int LINK_DIV = LINK_DIV_RAW + (LINK_DIV_RAW % 2); // Even split

   ////////////////////////////////////////////////////////////////////////////
   // Commands
   typedef enum logic [1:0] {
      CMD_PWM = 2'h0,   // Individual PWM words
      CMD_CAL = 2'h1,   // Current calibration bytes
      CMD_GLB = 2'h2,   // Global intensity byte twice
      CMD_CFG = 2'h3    // Configuration byte twice
   } cls_cmd_type;
endpackage

// File: pkg/cls_link_if.sv
// Purpose: Link wires between the host end and a cascaded driver end.
// Assumes: Host makes the link clock; every signal is one-way.
// Notes: In a chain, a device's return pair feeds the next device.
`timescale 1ns/1ns
interface cls_link_if;
   logic link_clk;    // Link clock, made by the host
   logic fwd_data;    // Serial data toward the device
   logic fwd_load;    // Load strobe toward the device
   logic ret_data;    // Serial data leaving the device
   logic ret_load;    // Load strobe leaving the device

   modport host_mp (
      output link_clk,
      output fwd_data,
      output fwd_load,
      input ret_data,
      input ret_load
   );

   modport dev_mp (
      input link_clk,
      input fwd_data,
      input fwd_load,
      output ret_data,
      output ret_load
   );
endinterface

// File: design/cls_fifo.sv
// Purpose: Word buffer with valid and ready on both sides.
// Assumes: One clock; depth of at least two.
// Notes: Room and non-empty are registered so the ports come from flops.
`timescale 1ns/1ns
module cls_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];        // Storage
   logic [AW-1:0] wp_q, wp_d;      // Write pointer
   logic [AW-1:0] rp_q, rp_d;      // Read pointer
   logic [AW:0] cnt_q, cnt_d;      // Fill level
   logic room_q, room_d;           // Room for a word
   logic nemp_q, nemp_d;           // At least one word
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      push = i_in_valid & room_q;
      pop = i_out_ready & nemp_q;
      wp_d = wp_q;
      rp_d = rp_q;
      // Pointers wrap by compare, so depth need not be a power of two
      if (push) begin
         wp_d = (wp_q == AW'(D - 1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (pop) begin
         rp_d = (rp_q == AW'(D - 1)) ? '0 : AW'(rp_q + 1'b1);
      end
      cnt_d = (AW + 1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      room_d = (cnt_d != (AW + 1)'(D));
      nemp_d = (cnt_d != '0);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         room_q <= 1'b0;
         nemp_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         room_q <= room_d;
         nemp_q <= nemp_d;
      end
   end

   // Storage needs no reset; reads are gated by the level
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_q[wp_q] <= i_in_data;
      end
   end

   assign o_in_ready = room_q;
   assign o_out_valid = nemp_q;
   assign o_out_data = mem_q[rp_q];
endmodule // cls_fifo

// File: design/cls_dev.sv
// Purpose: Driver end: keeps its own data set and passes the rest on.
// Assumes: Link clock runs; data and load are synchronous to it.
// Notes: The header leaves one data-set length plus one cycle late; later bits leave one cycle late.
//
// Behaviour
// - Intensity set: byte sent twice, 16 bits
// - Configuration set: byte sent twice, 16 bits
// - Plain PWM: one word per output, Z7..Y0
// - Multiplexed PWM: two words per output back-to-back
// - Capture first data set; never forward it
// - 16-bit set: new header after 17 cycles
// - Later data and tail forwarded one cycle late
// - Output delay equals set length plus one
// - Host reads returned counter, checks tail
// - Command low bit picks fault type counted
// - Open output adds one to counter
// - Increment is one, however many outputs open
// - Overtemperature blanks PWM and adds one
// - No fault: counter passes unchanged
// - Header: sync, command thrice, ten-bit counter
// - Command code selects load target
// - Calibration set: Z byte, then Y byte
// - Data and load sampled on rising edge
`timescale 1ns/1ns
module cls_dev #(
   parameter int PWM_W = cls_pkg::PWM_W_DEF
) (
   cls_link_if.dev_mp lnk,
   input wire logic i_nrst,
   input wire logic i_open_led,
   input wire logic i_over_temp,
   input wire logic i_mux_en,
   output logic o_set_valid,
   output logic [1:0] o_set_cmd,
   output logic [2*cls_pkg::OUTPUTS*PWM_W-1:0] o_set_data,
   output logic o_pwm_blank
);
   typedef enum logic [1:0] {
      DV_HUNT = 2'h0, DV_RX = 2'h1, DV_FWD = 2'h3
   } cls_dst_type;

   localparam int SET_MAX = 2 * cls_pkg::OUTPUTS * cls_pkg::PWM_W_DEF > 0 ?
                            2 * cls_pkg::OUTPUTS * PWM_W : 1;
   localparam int PW = cls_pkg::POS_W;
   localparam logic [PW-1:0] LEN_SHORT = PW'(cls_pkg::SET_SHORT);
   localparam logic [PW-1:0] LEN_PWM = PW'(cls_pkg::OUTPUTS * PWM_W);
   localparam logic [PW-1:0] HDR_N = PW'(cls_pkg::HDR_BITS);
   localparam logic [PW-1:0] CMD_N = PW'(cls_pkg::CMD_FIRST_BIT);

   cls_dst_type st_q, st_d;             // Frame state
   logic [PW-1:0] cyc_q, cyc_d;         // Input bit index in frame
   logic [PW-1:0] len_q, len_d;         // Own data set length
   logic [7:0] sr_q, sr_d;              // Sync hunt window
   logic [8:0] rx_q, rx_d;              // Header bits in flight
   logic [1:0] cmd_q, cmd_d;            // Received command
   logic [9:0] cnt_q, cnt_d;            // Counter to send on
   logic [SET_MAX-1:0] set_q, set_d;    // Own data set
   logic din_q;                         // Input data one cycle late
   logic ld_q;                          // Input load one cycle late
   logic dout_q, dout_d;                // Serial data out
   logic lout_q, lout_d;                // Load strobe out
   logic val_q, val_d;
   logic [1:0] ocmd_q, ocmd_d;
   logic [SET_MAX-1:0] odat_q, odat_d;
   logic blank_q;
   logic [2:0] fs1_q, fs2_q;            // Flag synchroniser: mux, hot, open
   logic [23:0] hdr;                    // Regenerated header
   logic [PW-1:0] hidx;                 // Header bit now leaving
   logic inc;                           // Selected fault present

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      cyc_d = cyc_q;
      len_d = len_q;
      sr_d = {sr_q[6:0], lnk.fwd_data};
      rx_d = rx_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      set_d = set_q;
      dout_d = 1'b0;
      lout_d = 1'b0;
      val_d = 1'b0;
      ocmd_d = ocmd_q;
      odat_d = odat_q;
      // Low command bit: set counts open outputs, clear counts heat
      inc = cmd_q[0] ? fs2_q[0] : fs2_q[1];
      hdr = {cls_pkg::SYNC_PAT, cmd_q, cmd_q, cmd_q, cnt_q};
      hidx = PW'(cyc_q - len_q - 1'b1);
      unique case (st_q)
         DV_HUNT: begin
            // Sync only counts while the load strobe is low
            if (sr_d == cls_pkg::SYNC_PAT && !lnk.fwd_load) begin
               st_d = DV_RX;
               cyc_d = CMD_N;
               set_d = '0;
            end
         end
         DV_RX: begin
            cyc_d = PW'(cyc_q + 1'b1);
            if (cyc_q < HDR_N) begin
               rx_d = {rx_q[7:0], lnk.fwd_data};
            end
            if (cyc_q == PW'(cls_pkg::CMD_SECOND_BIT)) begin
               cmd_d = {rx_q[0], lnk.fwd_data};
               // Set length follows the command and the mux setting
               if (cls_pkg::cls_cmd_type'({rx_q[0], lnk.fwd_data}) == cls_pkg::CMD_PWM) begin
                  len_d = fs2_q[2] ? PW'(2 * LEN_PWM) : LEN_PWM;
               end else begin
                  len_d = LEN_SHORT;
               end
            end
            // At most one is added, whatever the fault count on this device
            if (cyc_q == PW'(cls_pkg::CNT_LAST_BIT)) begin
               cnt_d = 10'({rx_q, lnk.fwd_data} + {9'h000, inc});
            end
            // Own set is shifted in and kept off the output
            if (cyc_q >= HDR_N && cyc_q < PW'(HDR_N + len_q)) begin
               set_d = {set_q[SET_MAX-2:0], lnk.fwd_data};
            end
            if (cyc_q == PW'(HDR_N + len_q - 1'b1)) begin
               val_d = 1'b1;
               ocmd_d = cmd_q;
               // Hot die forces every PWM word to zero
               if (cmd_q == cls_pkg::CMD_PWM && fs2_q[1]) begin
                  odat_d = '0;
               end else begin
                  odat_d = {set_q[SET_MAX-2:0], lnk.fwd_data};
               end
            end
            // Header leaves one set length plus one after it arrived
            if (cyc_q > len_q) begin
               dout_d = hdr[5'(23 - 32'(hidx[4:0]))];
            end
            lout_d = (cyc_q >= PW'(len_q + CMD_N + 1'b1));
            if (cyc_q == PW'(len_q + HDR_N)) begin
               st_d = DV_FWD;
            end
            // Strobe missing after its window: drop the frame
            if (cyc_q >= PW'(cls_pkg::LOAD_LATE_BIT) && !lnk.fwd_load) begin
               st_d = DV_HUNT;
               lout_d = 1'b0;
               dout_d = 1'b0;
            end
         end
         DV_FWD: begin
            // Remaining sets and tail pass with one cycle of delay
            dout_d = din_q;
            lout_d = ld_q;
            if (!ld_q) begin
               st_d = DV_HUNT;
            end
         end
         default: begin
            st_d = DV_HUNT;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers, all on the rising link edge
   always_ff @(posedge lnk.link_clk) begin
      if (!i_nrst) begin
         st_q <= DV_HUNT;
         cyc_q <= '0;
         len_q <= LEN_SHORT;
         sr_q <= '0;
         rx_q <= '0;
         cmd_q <= '0;
         cnt_q <= '0;
         set_q <= '0;
         din_q <= 1'b0;
         ld_q <= 1'b0;
         dout_q <= 1'b0;
         lout_q <= 1'b0;
         val_q <= 1'b0;
         ocmd_q <= '0;
         odat_q <= '0;
         blank_q <= 1'b0;
         fs1_q <= '0;
         fs2_q <= '0;
      end else begin
         st_q <= st_d;
         cyc_q <= cyc_d;
         len_q <= len_d;
         sr_q <= sr_d;
         rx_q <= rx_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         set_q <= set_d;
         din_q <= lnk.fwd_data;
         ld_q <= lnk.fwd_load;
         dout_q <= dout_d;
         lout_q <= lout_d;
         val_q <= val_d;
         ocmd_q <= ocmd_d;
         odat_q <= odat_d;
         // Blanking follows the hot flag; hysteresis lives in the sensor
         blank_q <= fs2_q[1];
         // Flags are asynchronous to the link clock
         fs1_q <= {i_mux_en, i_over_temp, i_open_led};
         fs2_q <= fs1_q;
      end
   end

   assign lnk.ret_data = dout_q;
   assign lnk.ret_load = lout_q;
   assign o_set_valid = val_q;
   assign o_set_cmd = ocmd_q;
   assign o_set_data = odat_q;
   assign o_pwm_blank = blank_q;
endmodule // cls_dev

// File: dv/cls_link_sva.sv
// Purpose: Wire checks on the link between the host end and one driver end.
// Assumes: One driver in the chain; 12-bit PWM words.
// Notes: Delays are measured from the cycle after the forward load rise to the return load rise.
`timescale 1ns/1ns
module cls_link_sva (
   input wire logic link_clk,
   input wire logic i_nrst,
   input wire logic fwd_data,
   input wire logic fwd_load,
   input wire logic ret_data,
   input wire logic ret_load,
   input wire logic i_mux_en
);
   logic [7:0] fsh_q, fsh_d; // Last eight forward bits
   logic [7:0] rsh_q, rsh_d; // Last eight return bits
   ////////////////////////////////////////////////////////////////////////////
   // History shifters; cleared so no stale bits fake a sync byte
   always_comb begin
      fsh_d = {fsh_q[6:0], fwd_data};
      rsh_d = {rsh_q[6:0], ret_data};
   end
   always_ff @(posedge link_clk) begin
      if (!i_nrst) begin
         fsh_q <= 8'h00;
         rsh_q <= 8'h00;
      end else begin
         fsh_q <= fsh_d;
         rsh_q <= rsh_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge link_clk); endclocking
   default disable iff (!i_nrst);
   a_fwd_sync_byte: assert property ($rose(fwd_load) |-> fsh_q == cls_pkg::SYNC_PAT)
      else $error("forward sync byte wrong at load rise");
   a_ret_sync_byte: assert property ($rose(ret_load) |-> rsh_q == cls_pkg::SYNC_PAT)
      else $error("returned sync byte wrong at load rise");
   a_ret_cmd_thrice: assert property ($rose(ret_load) |-> ##2
      (ret_data == $past(ret_data, 2))[*4]) else $error("returned command pair not repeated");
   a_short_set_delay: assert property ($rose(fwd_load) ##1 ($past(fwd_data) || fwd_data)
      |-> ##17 $rose(ret_load)) else $error("new header not 17 cycles late");
   a_pwm_set_delay: assert property ($rose(fwd_load) ##1 !($past(fwd_data) || fwd_data)
      && !i_mux_en |-> ##193 $rose(ret_load)) else $error("plain PWM header delay wrong");
   a_mux_set_delay: assert property ($rose(fwd_load) ##1 !($past(fwd_data) || fwd_data)
      && i_mux_en |-> ##[385:385] $rose(ret_load)) else $error("muxed PWM header delay wrong");
   a_tail_one_late: assert property ($fell(fwd_load) |=> ret_load
      && ret_data == $past(fwd_data, 2)) else $error("last tail bit not forwarded one cycle late");
   a_load_drop_late: assert property ($fell(fwd_load) |-> ##2 $fell(ret_load))
      else $error("return load did not drop one cycle after forward load");
endmodule // cls_link_sva

// File: dv/cascade_led_serial_link_test.sv
// Purpose: Host end and driver end joined; frames of every command checked.
// Assumes: One driver; host pauses the link clock while its buffer is dry.
// Notes: The 24-word muxed set overfills the buffer, so pushes stall.
`timescale 1ns/1ns
module cascade_led_serial_link_test;
   localparam int SW = 2 * cls_pkg::OUTPUTS * cls_pkg::PWM_W_DEF; // Widest set
   logic i_clk = 1'b0, i_nrst = 1'b0, dev_nrst = 1'b0, wr_valid = 1'b0, start = 1'b0;
   logic open_led = 1'b0, over_temp = 1'b0, mux_en = 1'b0; // Fault and mode levels
   logic [15:0] wr_data = 16'h0000, w;
   logic [1:0] cmd = 2'h0, set_cmd, got_cmd;
   logic [9:0] nwords = 10'h000, fault_cnt;
   logic [7:0] tail = 8'h00;
   logic wr_ready, busy, rx_done, tail_ok, set_valid, pwm_blank;
   logic [SW-1:0] set_data, got_data, exp_data;
   int err_count = 0, n_tests = 0, cycles = 0;
   // Case table: command, words, faults (bit0 open, bit1 hot, bit2 mux), count
   int c_t[6] = '{3, 2, 1, 0, 0, 0};
   int n_t[6] = '{1, 1, 1, 12, 24, 12};
   int f_t[6] = '{1, 1, 3, 0, 5, 2};
   int e_t[6] = '{1, 0, 1, 0, 0, 1};
   ////////////////////////////////////////////////////////////////////////////
   cls_link_if lnk();
   cls_host cls_host_i (.i_clk(i_clk), .i_nrst(i_nrst), .lnk(lnk), .i_wr_valid(wr_valid),
      .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_start(start), .i_cmd(cmd),
      .i_nwords(nwords), .i_tail(tail), .o_busy(busy), .o_rx_done(rx_done),
      .o_fault_cnt(fault_cnt), .o_tail_ok(tail_ok));
   cls_dev cls_dev_i (.lnk(lnk), .i_nrst(dev_nrst), .i_open_led(open_led),
      .i_over_temp(over_temp), .i_mux_en(mux_en), .o_set_valid(set_valid),
      .o_set_cmd(set_cmd), .o_set_data(set_data), .o_pwm_blank(pwm_blank));
   cls_link_sva cls_link_sva_i (.link_clk(lnk.link_clk), .i_nrst(dev_nrst),
      .fwd_data(lnk.fwd_data), .fwd_load(lnk.fwd_load), .ret_data(lnk.ret_data),
      .ret_load(lnk.ret_load), .i_mux_en(mux_en));
   ////////////////////////////////////////////////////////////////////////////
   initial forever #4 i_clk = ~i_clk;
   // Hang guard; six frames need well under a fifth of this
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         $display("ERROR timeout expected done seen none");
         end_sim();
      end
   end
   // Keep the set the driver captured for itself
   always @(posedge lnk.link_clk) if (set_valid === 1'b1) begin
      got_cmd = set_cmd;
      got_data = set_data;
   end
   task automatic chk(input string name, input logic [SW-1:0] exp, input logic [SW-1:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   // Offer one word and hold it until the buffer takes it
   task automatic push(input logic [15:0] d);
      wr_valid <= 1'b1;
      wr_data <= d;
      do @(posedge i_clk); while (wr_ready !== 1'b1);
   endtask
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (40) @(posedge i_clk); // Device reset needs link clock edges
      dev_nrst <= 1'b1;
      for (int k = 0; k < 6; k++) begin
         cmd <= 2'(c_t[k]);
         nwords <= 10'(n_t[k]);
         tail <= 8'h3C ^ 8'(k);
         open_led <= f_t[k][0];
         over_temp <= f_t[k][1];
         mux_en <= f_t[k][2];
         repeat (40) @(posedge i_clk); // Let the level synchronisers settle
         exp_data = '0;
         got_data = 'x;
         got_cmd = 'x;
         start <= 1'b1;
         @(posedge i_clk);
         start <= 1'b0;
         for (int i = 0; i < n_t[k]; i++) begin
            w = 16'hC35A ^ 16'(i * 311 + k);
            exp_data = (exp_data << 16) | SW'(w);
            push(w);
         end
         wr_valid <= 1'b0;
         while (rx_done !== 1'b1) @(posedge i_clk);
         if (f_t[k][1] && c_t[k] == 0) exp_data = '0;
         chk("fault count", SW'(e_t[k]), SW'(fault_cnt));
         chk("tail match", SW'(1), SW'(tail_ok));
         chk("set command", SW'(c_t[k]), SW'(got_cmd));
         chk("set data", exp_data, got_data);
         chk("blanking", SW'(f_t[k][1]), SW'(pwm_blank));
         $display("Test %0d done", k);
         while (busy !== 1'b0) @(posedge i_clk);
      end
      end_sim();
   end
endmodule // cascade_led_serial_link_test
